// ===== verilog/cic_pkg.sv
/*
  constants for the command and interrupt control register block.
  assumes a single 25 MHz clock and a byte-wide register port.
// How it works
// - offset 00h reserved, reads zero
// - operation control at 01h, resets 20h
// - receiver_off bit powers down receiver analog
// - writing soft_sleep one enters power-down
// - clearing soft_sleep wakes; reads one until ready
// - soft_sleep set ignored during soft reinit
// - opcode write launches; read shows running opcode
// - main enable at 02h, resets 80h, all RW
// - polarity invert bit inverts interrupt pin
// - main flags gated by enables bits 6..0
// - invert one plus open-drain gives three-state
// - secondary enable at 03h, resets 00h
// - output type bit selects push-pull or open-drain
// - bit 4 gates card input active request
// - bit 2 gates checksum done request
// - main request at 04h, resets 14h
// - write sets or clears marked flags by selector
// - transmit flag on last bit sent
// - receive flag on valid end, no-error option
// - idle flag on termination or unknown opcode
*/
package cic_pkg;
  localparam logic [5:0] ADDR_RSVD     = 6'h00;
  localparam logic [5:0] ADDR_OPCTRL   = 6'h01;
  localparam logic [5:0] ADDR_MAIN_EN  = 6'h02;
  localparam logic [5:0] ADDR_SEC_EN   = 6'h03;
  localparam logic [5:0] ADDR_MAIN_REQ = 6'h04;
  localparam logic [7:0] RST_OPCTRL    = 8'h20;
  localparam logic [7:0] RST_MAIN_EN   = 8'h80;
  localparam logic [7:0] RST_SEC_EN    = 8'h00;
  localparam logic [6:0] RST_MAIN_REQ  = 7'h14;
  localparam logic [7:0] SEC_EN_MASK   = 8'h94;
  localparam int BIT_RCV_OFF  = 5;
  localparam int BIT_SLEEP    = 4;
  localparam int BIT_INVERT   = 7;
  localparam int BIT_PUSHPULL = 7;
  localparam int BIT_SETSEL   = 7;
  localparam int BIT_CARD_EN  = 4;
  localparam int BIT_CRC_EN   = 2;
  localparam int BIT_TX_FLAG  = 6;
  localparam int BIT_RX_FLAG  = 5;
  localparam int BIT_IDLE_FLAG = 4;
  localparam int BIT_HIGH_FLAG  = 3;
  localparam int BIT_LOW_FLAG   = 2;
  localparam int BIT_FAULT_FLAG = 1;
  localparam int BIT_TIMER_FLAG = 0;
  localparam logic [3:0] OP_IDLE      = 4'h0;
  localparam logic [3:0] OP_REINIT    = 4'hf;
  // opcodes accepted as known; others fall back to idle
  localparam logic [15:0] OP_KNOWN    = 16'hb3ff;
  localparam int WAKE_NS = 1000;
  localparam int CLK_NS  = 40;
  localparam int WAKE_CYC = (WAKE_NS + CLK_NS - 1) / CLK_NS;
  localparam int REINIT_CYC = 8;
  typedef enum logic [1:0] {PwrAwake, PwrSleep, PwrWaking} cic_pwr_type;
endpackage

// ===== verilog/cic_regs.sv
/*
  command register and interrupt enable/request registers with pin drive.
  assumes host port strobes are one cycle and never both at once.
*/
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
module cic_regs
  import cic_pkg::*;
#(
  parameter int WAKE_CYCLES   = WAKE_CYC,
  parameter int REINIT_CYCLES = REINIT_CYC
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // host register port
  input  wire logic [5:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdData,
  // events from the rest of the front end
  input  wire logic       txLastBitSent,
  input  wire logic       rxValidEnd,
  input  wire logic       rxFifoHasData,
  input  wire logic       noErrorReceiveOption,
  input  wire logic       opDone,
  input  wire logic       highLevelEvent,
  input  wire logic       lowLevelEvent,
  input  wire logic       faultEvent,
  input  wire logic       countdownEvent,
  input  wire logic       cardInputActiveFlag,
  input  wire logic       checksumDoneFlag,
  // controls to the rest of the front end
  output logic            receiverOff,
  output logic            softSleep,
  output logic      [3:0] runningOp,
  output logic            opLaunch,
  // interrupt pin
  output logic            irqOut,
  output logic            irqOe
);

  localparam int WCW = $clog2(WAKE_CYCLES + 1) + 1;
  localparam int RCW = $clog2(REINIT_CYCLES + 1) + 1;

  typedef struct packed {
    logic              receiver_off;
    logic              sleepReq;
    logic              asleep;
    cic_pwr_type       pwr;
    logic [WCW-1:0]    wakeCnt;
    logic [3:0]        op;
    logic [RCW-1:0]    reinitCnt;
    logic              launch;
    logic [7:0]        mainEn;
    logic [7:0]        secEn;
    logic [6:0]        req;
    logic              combined;
    logic [7:0]        rdData;
    logic              pin;
    logic              oe;
  } cic_state_type;

  cic_state_type st_ff, nxt_st;

  function automatic logic opKnown(input logic [3:0] code);
    opKnown = OP_KNOWN[code];
  endfunction

  logic [7:0] opRead;
  logic       secAny;
  logic       irqNow;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.launch = 1'b0;
    // wake sequence
    case (st_ff.pwr)
      PwrAwake: begin
      end
      PwrSleep: begin
        if (!st_ff.sleepReq) begin
          nxt_st.pwr = PwrWaking;
          nxt_st.wakeCnt = WCW'(WAKE_CYCLES);
        end
      end
      PwrWaking: begin
        if (st_ff.wakeCnt <= WCW'(1)) begin
          nxt_st.pwr = PwrAwake;
          nxt_st.wakeCnt = '0;
        end else begin
          nxt_st.wakeCnt = st_ff.wakeCnt - WCW'(1);
        end
      end
      default: nxt_st.pwr = PwrAwake;
    endcase
    // soft reinit runs for a fixed time then returns to idle
    if (st_ff.op == OP_REINIT) begin
      if (st_ff.reinitCnt <= RCW'(1)) begin
        nxt_st.op = OP_IDLE;
        nxt_st.reinitCnt = '0;
      end else begin
        nxt_st.reinitCnt = st_ff.reinitCnt - RCW'(1);
      end
    end else if (opDone && st_ff.op != OP_IDLE) begin
      nxt_st.op = OP_IDLE;
    end
    // register writes
    if (regWr) begin
      case (regAddr)
        ADDR_OPCTRL: begin
          nxt_st.receiver_off = regWrData[BIT_RCV_OFF];
          if (regWrData[BIT_SLEEP]) begin
            if (st_ff.op != OP_REINIT) begin
              nxt_st.sleepReq = 1'b1;
              nxt_st.pwr = PwrSleep;
            end
          end else begin
            nxt_st.sleepReq = 1'b0;
          end
          if (opKnown(regWrData[3:0])) begin
            nxt_st.op = regWrData[3:0];
            nxt_st.launch = 1'b1;
            nxt_st.reinitCnt = RCW'(REINIT_CYCLES);
          end else begin
            nxt_st.op = OP_IDLE;
            nxt_st.req[BIT_IDLE_FLAG] = 1'b1;
          end
        end
        ADDR_MAIN_EN: nxt_st.mainEn = regWrData;
        ADDR_SEC_EN: nxt_st.secEn = regWrData & SEC_EN_MASK;
        ADDR_MAIN_REQ: begin
          if (regWrData[BIT_SETSEL]) nxt_st.req = st_ff.req | regWrData[6:0];
          else nxt_st.req = st_ff.req & ~regWrData[6:0];
        end
        default: begin
        end
      endcase
    end
    // events after the write so a set beats a same-cycle clear
    if (txLastBitSent) nxt_st.req[BIT_TX_FLAG] = 1'b1;
    if (rxValidEnd && (!noErrorReceiveOption || rxFifoHasData)) nxt_st.req[BIT_RX_FLAG] = 1'b1;
    if (st_ff.op != OP_IDLE && nxt_st.op == OP_IDLE) nxt_st.req[BIT_IDLE_FLAG] = 1'b1;
    if (highLevelEvent) nxt_st.req[BIT_HIGH_FLAG] = 1'b1;
    if (lowLevelEvent)  nxt_st.req[BIT_LOW_FLAG] = 1'b1;
    if (faultEvent)     nxt_st.req[BIT_FAULT_FLAG] = 1'b1;
    if (countdownEvent) nxt_st.req[BIT_TIMER_FLAG] = 1'b1;
    // registered so the sleep output comes straight from a flop
    nxt_st.asleep = (nxt_st.pwr != PwrAwake);
    // combined flag and pin
    secAny = (st_ff.secEn[BIT_CARD_EN] & cardInputActiveFlag)
           | (st_ff.secEn[BIT_CRC_EN] & checksumDoneFlag);
    irqNow = (|(st_ff.req & st_ff.mainEn[6:0])) | secAny;
    nxt_st.combined = irqNow;
    nxt_st.pin = irqNow ^ st_ff.mainEn[BIT_INVERT];
    // open-drain only pulls low; push-pull always drives
    nxt_st.oe = st_ff.secEn[BIT_PUSHPULL] | ~(irqNow ^ st_ff.mainEn[BIT_INVERT]);
    // read data, one cycle later
    opRead = {2'b00, st_ff.receiver_off, (st_ff.pwr != PwrAwake), st_ff.op};
    nxt_st.rdData = 8'h00;
    if (regRd) begin
      case (regAddr)
        ADDR_RSVD:     nxt_st.rdData = 8'h00;
        ADDR_OPCTRL:   nxt_st.rdData = opRead;
        ADDR_MAIN_EN:  nxt_st.rdData = st_ff.mainEn;
        ADDR_SEC_EN:   nxt_st.rdData = st_ff.secEn;
        ADDR_MAIN_REQ: nxt_st.rdData = {1'b0, st_ff.req};
        default:       nxt_st.rdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.receiver_off <= RST_OPCTRL[BIT_RCV_OFF];
      st_ff.pwr <= PwrAwake;
      st_ff.op <= OP_IDLE;
      st_ff.mainEn <= RST_MAIN_EN;
      st_ff.secEn <= RST_SEC_EN;
      st_ff.req <= RST_MAIN_REQ;
      st_ff.pin <= 1'b1;
      st_ff.oe <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign regRdData   = st_ff.rdData;
  assign receiverOff = st_ff.receiver_off;
  assign softSleep   = st_ff.asleep;
  assign runningOp   = st_ff.op;
  assign opLaunch    = st_ff.launch;
  assign irqOut      = st_ff.pin;
  assign irqOe       = st_ff.oe;

  // assertions
  AST_RSVD_READ: assert property (@(posedge sys_clk) disable iff (rst)
    regRd && regAddr == ADDR_RSVD |=> regRdData == 8'h00) else $error("reserved slot read nonzero");
  AST_RCV_OFF: assert property (@(posedge sys_clk) disable iff (rst)
    regWr && regAddr == ADDR_OPCTRL |=> receiverOff == $past(regWrData[BIT_RCV_OFF]))
    else $error("receiver off not taken");
  AST_SLEEP_ENTER: assert property (@(posedge sys_clk) disable iff (rst)
    regWr && regAddr == ADDR_OPCTRL && regWrData[BIT_SLEEP] && runningOp != OP_REINIT |=> softSleep)
    else $error("sleep not entered");
  AST_REINIT_BLOCK: assert property (@(posedge sys_clk) disable iff (rst)
    !softSleep && regWr && regAddr == ADDR_OPCTRL && regWrData[BIT_SLEEP] && runningOp == OP_REINIT |=> !softSleep)
    else $error("sleep set during reinit");
  AST_WAKE_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(st_ff.sleepReq) |-> softSleep [*2]) else $error("woke too early");
  AST_REQ_CLEAR: assert property (@(posedge sys_clk) disable iff (rst)
    regWr && regAddr == ADDR_MAIN_REQ && !regWrData[BIT_SETSEL] && regWrData[0] && !countdownEvent
    |=> !st_ff.req[0]) else $error("flag not cleared");
  AST_TX_FLAG: assert property (@(posedge sys_clk) disable iff (rst)
    txLastBitSent |=> st_ff.req[BIT_TX_FLAG]) else $error("tx flag missing");
  AST_PIN_POL: assert property (@(posedge sys_clk) disable iff (rst)
    1'b1 |-> irqOut == (st_ff.combined ^ $past(st_ff.mainEn[BIT_INVERT]))) else $error("pin polarity wrong");
  AST_COMBINED: assert property (@(posedge sys_clk) disable iff (rst)
    1'b1 |=> st_ff.combined == ((|($past(st_ff.req) & $past(st_ff.mainEn[6:0])))
      | ($past(st_ff.secEn[BIT_CARD_EN]) & $past(cardInputActiveFlag))
      | ($past(st_ff.secEn[BIT_CRC_EN]) & $past(checksumDoneFlag)))) else $error("combined flag wrong");
  AST_OPEN_DRAIN: assert property (@(posedge sys_clk) disable iff (rst)
    !st_ff.secEn[BIT_PUSHPULL] |=> irqOe == !irqOut) else $error("open-drain drives high");
  AST_MAIN_EN_WR: assert property (@(posedge sys_clk) disable iff (rst)
    regWr && regAddr == ADDR_MAIN_EN |=> st_ff.mainEn == $past(regWrData)) else $error("main enable not written");
  AST_SEC_EN_WR: assert property (@(posedge sys_clk) disable iff (rst)
    regWr && regAddr == ADDR_SEC_EN |=> st_ff.secEn == ($past(regWrData) & SEC_EN_MASK))
    else $error("secondary enable wrong");
  AST_RD_QUIET: assert property (@(posedge sys_clk) disable iff (rst)
    !regRd |=> regRdData == 8'h00) else $error("read data without read");
  AST_REQ_READ: assert property (@(posedge sys_clk) disable iff (rst)
    regRd && regAddr == ADDR_MAIN_REQ |=> regRdData == {1'b0, $past(st_ff.req)}) else $error("request read wrong");
  AST_OP_READ: assert property (@(posedge sys_clk) disable iff (rst)
    regRd && regAddr == ADDR_OPCTRL |=> regRdData[3:0] == $past(runningOp) && regRdData[7:6] == 2'b00)
    else $error("opcode read wrong");
  AST_LAUNCH: assert property (@(posedge sys_clk) disable iff (rst)
    regWr && regAddr == ADDR_OPCTRL && opKnown(regWrData[3:0]) |=> opLaunch && runningOp == $past(regWrData[3:0]))
    else $error("opcode not launched");
  AST_RX_FLAG: assert property (@(posedge sys_clk) disable iff (rst)
    rxValidEnd && (!noErrorReceiveOption || rxFifoHasData) |=> st_ff.req[BIT_RX_FLAG]) else $error("rx flag missing");
  AST_REQ_SET: assert property (@(posedge sys_clk) disable iff (rst)
    regWr && regAddr == ADDR_MAIN_REQ && regWrData[BIT_SETSEL]
    |=> (st_ff.req & $past(regWrData[6:0])) == $past(regWrData[6:0])) else $error("flags not set");
  AST_UNKNOWN_OP: assert property (@(posedge sys_clk) disable iff (rst)
    regWr && regAddr == ADDR_OPCTRL && !opKnown(regWrData[3:0]) |=> runningOp == OP_IDLE && st_ff.req[BIT_IDLE_FLAG])
    else $error("unknown opcode not idled");
  AST_PUSHPULL: assert property (@(posedge sys_clk) disable iff (rst)
    st_ff.secEn[BIT_PUSHPULL] |=> irqOe) else $error("push-pull not driving");

  COV_SLEEP_WAKE: cover property (@(posedge sys_clk) disable iff (rst) softSleep ##[1:40] !softSleep);
  COV_IRQ: cover property (@(posedge sys_clk) disable iff (rst) st_ff.combined);
  COV_UNKNOWN: cover property (@(posedge sys_clk) disable iff (rst) $rose(st_ff.req[BIT_IDLE_FLAG]));
  COV_PUSHPULL: cover property (@(posedge sys_clk) disable iff (rst) st_ff.secEn[BIT_PUSHPULL] && irqOe && irqOut);
  COV_REINIT_BLOCK: cover property (@(posedge sys_clk) disable iff (rst)
    regWr && regAddr == ADDR_OPCTRL && regWrData[BIT_SLEEP] && runningOp == OP_REINIT);
endmodule

// ===== verification/cic_host_model.sv
/*
  host side of the interrupt pin: resolves the wire level.
  assumes an external pull-up on the line when nobody drives it.
*/
`timescale 1ns/100ps
module cic_host_model (
  // pin from the block
  input  wire logic irqOut,
  input  wire logic irqOe,
  // level the host samples
  output logic      irqLine
);
  // released line floats up, never keeps the last driven value
  assign irqLine = irqOe ? irqOut : 1'b1;
endmodule

// ===== verification/command_and_irq_control_regs_tb.sv
/*
  self-checking bench for cic_regs: registers, events, pin.
  assumes 40 ns clock and a shortened wake-up count.
*/
`timescale 1ns/100ps
module command_and_irq_control_regs_tb;
  import cic_pkg::*;
  logic       sys_clk, rst, regWr, regRd, fifoData, noErr, opDone, cardAct, crcDone, irqLine;
  logic [5:0] regAddr, ev;
  logic [7:0] regWrData, regRdData;
  logic       receiverOff, softSleep, opLaunch, irqOut, irqOe;
  logic [3:0] runningOp;
  int         mismatches, totalChecks, i;
  int         evBit [6] = '{6, 5, 3, 2, 1, 0};
  // short wake count keeps the run brief
  cic_regs #(.WAKE_CYCLES(2), .REINIT_CYCLES(8)) dut (
    .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .txLastBitSent(ev[0]), .rxValidEnd(ev[1]),
    .rxFifoHasData(fifoData), .noErrorReceiveOption(noErr), .opDone(opDone),
    .highLevelEvent(ev[2]), .lowLevelEvent(ev[3]), .faultEvent(ev[4]), .countdownEvent(ev[5]),
    .cardInputActiveFlag(cardAct), .checksumDoneFlag(crcDone), .receiverOff(receiverOff),
    .softSleep(softSleep), .runningOp(runningOp), .opLaunch(opLaunch), .irqOut(irqOut), .irqOe(irqOe));
  cic_host_model host (.irqOut(irqOut), .irqOe(irqOe), .irqLine(irqLine));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    totalChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWr <= 1'b1; regAddr <= a; regWrData <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    regRd <= 1'b1; regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 chk(regRdData, exp);
  endtask
  task automatic pin(input logic lvl, input logic oe);
    repeat (3) @(posedge sys_clk);
    #1 chk({7'h00, irqLine}, {7'h00, lvl});
    chk({7'h00, irqOe}, {7'h00, oe});
  endtask
  task automatic pulse_ev(input int k);
    @(posedge sys_clk);
    ev[k] <= 1'b1;
    @(posedge sys_clk);
    ev[k] <= 1'b0;
  endtask
  task automatic sc_reset;
    #1 pin(1'b1, 1'b0);
    rd(6'h00, 8'h00);
    rd(6'h01, RST_OPCTRL);
    rd(6'h02, 8'h80);
    rd(6'h03, 8'h00);
    rd(6'h04, 8'h14);
    rd(6'h05, 8'h00);
    wr(6'h00, 8'hff);
    rd(6'h00, 8'h00);
    wr(6'h03, 8'hff);
    rd(6'h03, 8'h94);
    wr(6'h02, 8'h5a);
    rd(6'h02, 8'h5a);
  endtask
  task automatic sc_events;
    wr(6'h03, 8'h00);
    wr(6'h04, 8'h7f);
    rd(6'h04, 8'h00);
    wr(6'h04, 8'h8a);
    rd(6'h04, 8'h0a);
    wr(6'h04, 8'h08);
    rd(6'h04, 8'h02);
    wr(6'h04, 8'h7f);
    for (i = 0; i < 6; i++) begin
      pulse_ev(i);
      rd(6'h04, 8'(8'h01 << evBit[i]));
      wr(6'h04, 8'h7f);
    end
    noErr <= 1'b1;
    pulse_ev(1);
    rd(6'h04, 8'h00);
    @(posedge sys_clk);
    fifoData <= 1'b1;
    pulse_ev(1);
    rd(6'h04, 8'h20);
    wr(6'h04, 8'h7f);
  endtask
  task automatic sc_pin;
    wr(6'h02, 8'h00);
    pin(1'b0, 1'b1);
    wr(6'h02, 8'h01);
    wr(6'h04, 8'h81);
    pin(1'b1, 1'b0);
    wr(6'h02, 8'h81);
    pin(1'b0, 1'b1);
    wr(6'h03, 8'h80);
    wr(6'h02, 8'h01);
    pin(1'b1, 1'b1);
    wr(6'h04, 8'h01);
    wr(6'h02, 8'h00);
    wr(6'h03, 8'h90);
    cardAct <= 1'b1;
    pin(1'b1, 1'b1);
    @(posedge sys_clk);
    cardAct <= 1'b0;
    wr(6'h03, 8'h84);
    crcDone <= 1'b1;
    pin(1'b1, 1'b1);
    @(posedge sys_clk);
    crcDone <= 1'b0;
    pin(1'b0, 1'b1);
  endtask
  task automatic sc_command;
    wr(6'h01, 8'h00);
    #1 chk({7'h00, receiverOff}, 8'h00);
    wr(6'h01, 8'h20);
    #1 chk({7'h00, receiverOff}, 8'h01);
    wr(6'h01, 8'h01);
    #1 chk({7'h00, opLaunch}, 8'h01);
    rd(6'h01, 8'h01);
    @(posedge sys_clk);
    opDone <= 1'b1;
    @(posedge sys_clk);
    opDone <= 1'b0;
    rd(6'h04, 8'h10);
    wr(6'h04, 8'h7f);
    wr(6'h01, 8'h0a);
    rd(6'h01, 8'h00);
    rd(6'h04, 8'h10);
    wr(6'h01, 8'h10);
    #1 chk({7'h00, softSleep}, 8'h01);
    wr(6'h01, 8'h00);
    rd(6'h01, 8'h10);
    for (i = 0; i < 20 && softSleep !== 1'b0; i++) @(posedge sys_clk);
    if (i == 20) mismatches++;
    rd(6'h01, 8'h00);
    wr(6'h01, OP_REINIT);
    wr(6'h01, 8'h1f);
    #1 chk({7'h00, softSleep}, 8'h00);
  endtask
  initial begin
    rst = 1'b1; regWr = 1'b0; regRd = 1'b0; regAddr = 6'h00; regWrData = 8'h00; ev = 6'h00;
    fifoData = 1'b0; noErr = 1'b0; opDone = 1'b0; cardAct = 1'b0; crcDone = 1'b0;
    mismatches = 0; totalChecks = 0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    sc_reset;
    sc_events;
    sc_pin;
    sc_command;
    final_report;
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    final_report;
  end
endmodule
